// File: core/ecpm_top.sv
// event channel priority map with cpu action control stage
// assumes requesters hold their request until ack or deny,
// and the cpu answers an action with a one-cycle ack or deny
`timescale 1ns/1ps
`include "ecpm_params.svh"

// Notes on behaviour
// - only winners at level 8-15, group 0-3 may get a transfer
// - channel level is 1, inverted level select, channel bit 2
// - channel group is 0 then the two low channel bits
// - no extended group for transfers; eight channels in four groups of two
// - unmatched requests go on as normal interrupts
// - winner and debug request multiplexed into one cpu action
// - cpu ack or deny returned to the requester it concerns
// - debug request has programmable level; higher level goes first
// - equal levels: interrupt or transfer beats debug
// - debug break goes straight through, untouched
// - link bit in a pair disables the odd channel's mapping
// - channel enabled only while its count is nonzero
module ecpm_top
(
  input  wire logic              ref_clk,
  input  wire logic              rst,
  input  wire logic [7:0]        s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [7:0]        s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              arb_valid,
  input  wire logic [3:0]        arb_interrupt_level,
  input  wire logic [2:0]        arb_glvl,
  output logic                   arb_ack,
  output logic                   arb_deny,
  input  wire logic              dbg_req,
  output logic                   dbg_ack,
  output logic                   dbg_deny,
  input  wire logic              dbg_brk_in,
  output logic                   dbg_brk_out,
  output logic                   act_valid,
  output ecpm_pkg::ecpm_act_t    act_kind,
  output logic [3:0]             act_interrupt_level,
  output logic [2:0]             act_chan,
  input  wire logic              cpu_ack,
  input  wire logic              cpu_deny,
  output logic                   irq
);
  import ecpm_pkg::*;

  // ========================================================
  // helpers
  // linked level of channel x for a level select setting
  function automatic logic [3:0] chan_interrupt_level(input logic [2:0] x,
                                           input logic [1:0] ls);
    chan_interrupt_level = {1'b1, ~ls, x[2]};
  endfunction : chan_interrupt_level

  function automatic logic [2:0] chan_glvl(input logic [2:0] x);
    chan_glvl = {1'b0, x[1:0]};
  endfunction : chan_glvl

  // ========================================================
  // state
  logic [15:0]  chan_q [8];
  logic [3:0]   dbg_lvl_q;
  logic [3:0]   stat_q;
  logic [3:0]   en_q;
  logic [2:0]   last_chan_q;
  logic         bvalid_q;
  logic [1:0]   bresp_q;
  logic         rvalid_q;
  logic [1:0]   rresp_q;
  logic [31:0]  rdata_q;
  ecpm_state_t  st_q;
  ecpm_act_t    kind_q;
  logic [3:0]   interrupt_level_q;
  logic [2:0]   chan_sel_q;

  // ========================================================
  // channel matching
  logic [7:0]   hit;
  logic         xfer_any;
  logic [2:0]   hit_idx;

  // one comparator per channel; odd channel drops out if linked
  for (genvar i = 0; i < 8; i++)
  begin : g_match
    wire [2:0] ci   = 3'(i);
    wire [15:0] pr  = chan_q[i ^ 1];
    wire link_pair  = chan_q[i][`ECPM_F_LINK] | pr[`ECPM_F_LINK];
    wire cnt_nz     = chan_q[i][`ECPM_F_CNT +: 8] != 8'h00;
    assign hit[i]   = arb_valid & cnt_nz
      & ~(ci[0] & link_pair)
      & (arb_interrupt_level == chan_interrupt_level(ci, chan_q[i][`ECPM_F_LSEL +: 2]))
      & (arb_glvl == chan_glvl(ci));
  end

  // lowest hit wins should two channels share a level select
  assign xfer_any = |hit;
  assign hit_idx  = hit[0] ? 3'h0 : hit[1] ? 3'h1 : hit[2] ? 3'h2 :
                    hit[3] ? 3'h3 : hit[4] ? 3'h4 : hit[5] ? 3'h5 :
                    hit[6] ? 3'h6 : 3'h7;

  // ========================================================
  // action control selection
  wire idle      = st_q == ST_IDLE;
  wire busy      = st_q == ST_BUSY;
  wire pick_irq  = arb_valid & (~dbg_req | arb_interrupt_level >= dbg_lvl_q);
  wire issue     = idle & (arb_valid | dbg_req);
  wire done      = busy & (cpu_ack | cpu_deny);
  wire xfer_done = busy & cpu_ack & kind_q == ACT_XFER;
  wire is_dbg    = kind_q == ACT_DBG;

  // answers routed back by owner of the pending action
  assign arb_ack     = busy & cpu_ack & ~is_dbg;
  assign arb_deny    = busy & cpu_deny & ~is_dbg;
  assign dbg_ack     = busy & cpu_ack & is_dbg;
  assign dbg_deny    = busy & cpu_deny & is_dbg;
  assign dbg_brk_out = dbg_brk_in;

  // action register; held stable until the cpu answers
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      st_q       <= ST_IDLE;
      kind_q     <= ACT_IRQ;
      interrupt_level_q     <= 4'h0;
      chan_sel_q <= 3'h0;
    end
    else if (issue)
    begin
      st_q       <= ST_BUSY;
      // higher level first, ties to the interrupt side
      kind_q     <= !pick_irq ? ACT_DBG :
                    xfer_any ? ACT_XFER : ACT_IRQ;
      interrupt_level_q     <= pick_irq ? arb_interrupt_level : dbg_lvl_q;
      chan_sel_q <= hit_idx;
    end
    else if (done)
      st_q <= ST_IDLE;
  end

  assign act_valid = busy;
  assign act_kind  = kind_q;
  assign act_interrupt_level  = interrupt_level_q;
  assign act_chan  = chan_sel_q;

  // ========================================================
  // axi4-lite decode
  wire        wr_go   = s_axi_awvalid & s_axi_wvalid & ~bvalid_q;
  wire        rd_go   = s_axi_arvalid & ~rvalid_q;
  wire [7:0]  wa      = s_axi_awaddr;
  wire [7:0]  ra      = s_axi_araddr;
  wire        wa_chan = wa[7:5] == 3'h0 && wa[1:0] == 2'h0;
  wire        ra_chan = ra[7:5] == 3'h0 && ra[1:0] == 2'h0;
  wire        w_dbg   = wa == `ECPM_OFF_DBGLVL;
  wire        w_clr   = wa == `ECPM_OFF_CLR;
  wire        w_en    = wa == `ECPM_OFF_EN;
  // status and serve are read-only, so a write there errors
  wire        w_ok    = wa_chan | w_dbg | w_clr | w_en;
  wire [3:0]  clr     = (wr_go & w_clr & s_axi_wstrb[0]) ?
                        s_axi_wdata[3:0] : 4'h0;
  wire [31:0] rmux    =
    ra_chan ? {16'h0000, chan_q[ra[4:2]]} :
    ra == `ECPM_OFF_DBGLVL ? {28'h0, dbg_lvl_q} :
    ra == `ECPM_OFF_STAT ? {28'h0, stat_q} :
    ra == `ECPM_OFF_EN ? {28'h0, en_q} :
    ra == `ECPM_OFF_SERVE ? {28'h0, xfer_any, last_chan_q} : 32'h0;
  wire        r_ok    = ra_chan | ra == `ECPM_OFF_DBGLVL |
                        ra == `ECPM_OFF_STAT | ra == `ECPM_OFF_EN |
                        ra == `ECPM_OFF_SERVE;

  assign s_axi_awready = wr_go;
  assign s_axi_wready  = wr_go;
  assign s_axi_arready = rd_go;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rresp   = rresp_q;
  assign s_axi_rdata   = rdata_q;

  // write and read answers, one cycle after acceptance
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      bvalid_q <= 1'b0;
      bresp_q  <= `ECPM_RESP_OK;
      rvalid_q <= 1'b0;
      rresp_q  <= `ECPM_RESP_OK;
      rdata_q  <= 32'h0;
    end
    else
    begin
      if (wr_go)
      begin
        bvalid_q <= 1'b1;
        bresp_q  <= w_ok ? `ECPM_RESP_OK : `ECPM_RESP_ERR;
      end
      else if (s_axi_bready)
        bvalid_q <= 1'b0;
      if (rd_go)
      begin
        rvalid_q <= 1'b1;
        rresp_q  <= r_ok ? `ECPM_RESP_OK : `ECPM_RESP_ERR;
        rdata_q  <= rmux;
      end
      else if (s_axi_rready)
        rvalid_q <= 1'b0;
    end
  end

  // ========================================================
  // channel control; software write wins over the count step
  for (genvar i = 0; i < 8; i++)
  begin : g_chan
    wire wsel = wr_go & wa_chan & wa[4:2] == 3'(i);
    always_ff @(posedge ref_clk)
    begin
      if (rst)
        chan_q[i] <= `ECPM_RST_CHAN;
      else
      begin
        if (wsel & s_axi_wstrb[0])
          chan_q[i][7:0] <= s_axi_wdata[7:0];
        if (wsel & s_axi_wstrb[1])
          chan_q[i][15:8] <= s_axi_wdata[15:8];
        else if (xfer_done & chan_sel_q == 3'(i) &
                 chan_q[i][15:8] != 8'h00)
          chan_q[i][15:8] <= chan_q[i][15:8] - 8'h01;
      end
    end
  end

  // ========================================================
  // debug level, interrupt status and enable
  // events: 0 transfer, 1 normal irq, 2 debug action, 3 deny
  wire [3:0] ev = {done & cpu_deny & ~cpu_ack,
                   busy & cpu_ack & is_dbg,
                   busy & cpu_ack & kind_q == ACT_IRQ,
                   xfer_done};

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      dbg_lvl_q   <= `ECPM_RST_DBGLVL;
      en_q        <= `ECPM_RST_EN;
      stat_q      <= 4'h0;
      last_chan_q <= 3'h0;
    end
    else
    begin
      if (wr_go & w_dbg & s_axi_wstrb[0])
        dbg_lvl_q <= s_axi_wdata[3:0];
      if (wr_go & w_en & s_axi_wstrb[0])
        en_q <= s_axi_wdata[3:0];
      stat_q <= (stat_q & ~clr) | ev; // set beats clear
      if (xfer_done)
        last_chan_q <= chan_sel_q;
    end
  end

  assign irq = |(stat_q & en_q);

  // ========================================================
  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  sequence s_issue_xfer;
    issue & pick_irq & xfer_any ##1 act_kind == ACT_XFER;
  endsequence
  sequence s_dbg_over;
    issue & dbg_req & arb_valid & (dbg_lvl_q > arb_interrupt_level);
  endsequence

  xfer_level_a: assert property (s_issue_xfer |-> act_interrupt_level[3])
    else $error("transfer issued below level 8");
  level_map_a: assert property (
    s_issue_xfer |-> act_interrupt_level[0] == act_chan[2] &&
      act_interrupt_level[2:1] == ~$past(chan_q[hit_idx][1:0]))
    else $error("transfer level does not match channel");
  group_map_a: assert property (
    s_issue_xfer |-> $past(arb_glvl) == {1'b0, act_chan[1:0]})
    else $error("transfer group does not match channel");
  no_group_ext_a: assert property (
    issue & arb_glvl[2] |-> ##1 act_kind != ACT_XFER)
    else $error("extended group took a transfer");
  normal_pass_a: assert property (
    issue & arb_valid & ~dbg_req & ~xfer_any
      |=> act_valid && act_kind == ACT_IRQ)
    else $error("unmatched request not passed on");
  hold_action_a: assert property (
    act_valid & ~cpu_ack & ~cpu_deny
      |=> act_valid && $stable(act_kind) && $stable(act_interrupt_level))
    else $error("action changed before answer");
  ack_route_a: assert property (
    busy & cpu_ack |-> (dbg_ack ^ arb_ack) && dbg_ack == is_dbg)
    else $error("ack routed to wrong requester");
  dbg_first_a: assert property (
    s_dbg_over |=> act_valid && act_kind == ACT_DBG &&
      act_interrupt_level == $past(dbg_lvl_q))
    else $error("higher debug level not served first");
  tie_irq_a: assert property (
    issue & dbg_req & arb_valid & (dbg_lvl_q == arb_interrupt_level)
      |=> act_kind != ACT_DBG)
    else $error("debug beat interrupt at equal level");
  brk_pass_a: assert property (
    dbg_brk_out == dbg_brk_in)
    else $error("break request not passed through");
  odd_drop_a: assert property (
    s_issue_xfer |-> !(act_chan[0] &&
      ($past(chan_q[hit_idx][2]) || $past(chan_q[hit_idx ^ 3'h1][2]))))
    else $error("linked odd channel took a transfer");
  cnt_enable_a: assert property (
    s_issue_xfer |-> $past(chan_q[hit_idx][15:8]) != 8'h00)
    else $error("transfer on channel with zero count");
endmodule : ecpm_top

// File: inc/ecpm_params.svh
// event channel priority map: offsets, fields, reset values
// assumes 32-bit axi4-lite words, byte addresses, 8-bit address bus
`ifndef ECPM_PARAMS_SVH
`define ECPM_PARAMS_SVH
// ==========================================================
// register byte offsets
`define ECPM_OFF_CHAN   8'h00
`define ECPM_OFF_DBGLVL 8'h20
`define ECPM_OFF_STAT   8'h24
`define ECPM_OFF_CLR    8'h28
`define ECPM_OFF_EN     8'h2C
`define ECPM_OFF_SERVE  8'h30
// ==========================================================
// channel control field positions
`define ECPM_F_LSEL     0
`define ECPM_F_LINK     2
`define ECPM_F_CNT      8
// ==========================================================
// reset values and bus answers
`define ECPM_RST_CHAN   16'h0000
`define ECPM_RST_DBGLVL 4'h0
`define ECPM_RST_EN     4'h0
`define ECPM_RESP_OK    2'h0
`define ECPM_RESP_ERR   2'h2
`endif

// File: inc/ecpm_pkg.sv
// event channel priority map: shared types
// assumes ecpm_params.svh holds all numeric constants
package ecpm_pkg;
  // ========================================================
  // action controller states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_BUSY = 2'b10
  } ecpm_state_t;
  // ========================================================
  // kind of action demanded from the cpu
  typedef enum logic [1:0] {
    ACT_IRQ  = 2'h0,
    ACT_XFER = 2'h1,
    ACT_DBG  = 2'h2
  } ecpm_act_t;
endpackage : ecpm_pkg

// File: bench/ecpm_cpu_model.sv
// cpu core model: answers every demanded action with ack or deny
// assumes act_valid stays high until the edge that sees the answer
`timescale 1ns/1ps
// ==========================================================
// cpu answer model
module ecpm_cpu_model
(
  input  wire logic       ref_clk,
  input  wire logic       rst,
  input  wire logic       act_valid,
  input  wire logic       deny_en,
  input  wire logic [1:0] slow,
  output logic            cpu_ack,
  output logic            cpu_deny
);
  // one-cycle answer after 0..3 wait cycles; deny only when told
  initial
  begin
    cpu_ack = 1'b0;
    cpu_deny = 1'b0;
    forever
    begin
      @(posedge ref_clk);
      if (!rst && act_valid === 1'b1)
      begin
        repeat (slow) @(posedge ref_clk);
        cpu_ack <= !deny_en;
        cpu_deny <= deny_en;
        @(posedge ref_clk);
        cpu_ack <= 1'b0;
        cpu_deny <= 1'b0;
        @(posedge ref_clk); // skip the cycle where act_valid drops
      end
    end
  end
endmodule : ecpm_cpu_model

// File: bench/event_channel_priority_map_tb.sv
// self-checking bench for the event channel priority map
// assumes the cpu model answers; the bench is requester and bus master
`timescale 1ns/1ps
`include "ecpm_params.svh"
module event_channel_priority_map_tb;
  import ecpm_pkg::*;
  // ==========================================================
  // signals and reference model state
  logic        ref_clk, rst, awv, wv, bq, arv, rq, arb_v, dreq, brk;
  logic        den, awr, wr, bv, arr, rv, a_ack, a_den, d_ack, d_den;
  logic        brk_o, av, cack, cden, irq, pa, pd;
  logic [1:0]  br, rr, slow;
  logic [1:0]  ls [8];
  logic        lk [8];
  logic [2:0]  gl, ac;
  logic [3:0]  il, al;
  logic [7:0]  awa, ara;
  logic [31:0] wd, rd;
  ecpm_act_t   ak;
  int          cnt [8];
  int          stat, dl, lc, errors, compares;
  int          cyc = 0;

  // ==========================================================
  // design and cpu model
  ecpm_top i_ecpm_top
  (
    .ref_clk(ref_clk), .rst(rst), .s_axi_awaddr(awa),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wr),
    .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bq),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rd), .s_axi_rresp(rr), .s_axi_rvalid(rv),
    .s_axi_rready(rq), .arb_valid(arb_v), .arb_interrupt_level(il), .arb_glvl(gl),
    .arb_ack(a_ack), .arb_deny(a_den), .dbg_req(dreq), .dbg_ack(d_ack),
    .dbg_deny(d_den), .dbg_brk_in(brk), .dbg_brk_out(brk_o),
    .act_valid(av), .act_kind(ak), .act_interrupt_level(al), .act_chan(ac),
    .cpu_ack(cack), .cpu_deny(cden), .irq(irq)
  );
  ecpm_cpu_model i_ecpm_cpu_model
  (
    .ref_clk(ref_clk), .rst(rst), .act_valid(av), .deny_en(den),
    .slow(slow), .cpu_ack(cack), .cpu_deny(cden)
  );

  // ==========================================================
  // clock and hang guard
  initial
  begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      errors = errors + 1;
      summarize();
    end
  end

  // ==========================================================
  // checking and bus tasks
  task automatic chk(input logic ok, input string m);
    compares = compares + 1;
    if (ok !== 1'b1)
    begin
      errors = errors + 1;
      $display("Error at %0t: %s mismatch", $time, m);
    end
  endtask : chk
  task automatic summarize();
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : summarize
  // write: address and data offered together, held until taken
  task automatic axw(input logic [7:0] a, input logic [31:0] d,
                     input logic [1:0] r);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bq <= 1'b1;
    do @(posedge ref_clk); while ((awr & wr) !== 1'b1);
    awv <= 1'b0;
    wv <= 1'b0;
    do @(posedge ref_clk); while (bv !== 1'b1);
    bq <= 1'b0;
    chk(br === r, "write response");
    @(posedge ref_clk); // keeps bready from toggling twice in a step
  endtask : axw
  task automatic axr(input logic [7:0] a, input logic [31:0] d,
                     input logic [1:0] r);
    ara <= a;
    arv <= 1'b1;
    rq <= 1'b1;
    do @(posedge ref_clk); while (arr !== 1'b1);
    arv <= 1'b0;
    do @(posedge ref_clk); while (rv !== 1'b1);
    rq <= 1'b0;
    chk(rd === d && rr === r, "read");
    @(posedge ref_clk);
  endtask : axr
  task automatic wch(input int x);
    axw(8'(4 * x), {16'h0, 8'(cnt[x]), 5'h0, lk[x], ls[x]},
        `ECPM_RESP_OK);
  endtask : wch
  // reference: lowest enabled channel, bar the odd one of a linked pair, whose pair matches
  function automatic int mch(input logic [3:0] l, input logic [2:0] g);
    for (int x = 0; x < 8; x++)
      if (cnt[x] > 0 && !(x % 2 == 1 && (lk[x] || lk[x - 1]))
          && l == {1'b1, ~ls[x], 1'(x / 4)} && g == {1'b0, 2'(x)})
        return x;
    return -1;
  endfunction : mch
  // raise requests, then follow each action to its answer
  task automatic run(input logic a, input logic d, input logic [3:0] l,
                     input logic [2:0] g);
    int   ch;
    logic ia;
    arb_v <= a;
    dreq <= d;
    il <= l;
    gl <= g;
    pa = a;
    pd = d;
    while (pa || pd)
    begin
      ch = mch(l, g);
      ia = pa && (!pd || l >= dl);
      slow <= 2'($urandom);
      den <= ($urandom % 4) == 0;
      do @(posedge ref_clk); while (av !== 1'b1);
      chk(ak === (!ia ? ACT_DBG : (ch < 0 ? ACT_IRQ : ACT_XFER)),
          "kind");
      chk(al === (ia ? l : 4'(dl)), "action level");
      if (ia && ch >= 0) chk(ac === 3'(ch), "channel");
      do @(posedge ref_clk); while ((cack | cden) !== 1'b1);
      chk({a_ack, a_den, d_ack, d_den} === (ia ? {cack, cden, 2'b00}
          : {2'b00, cack, cden}), "answer routing");
      stat = stat | (cden ? 8 : (!ia ? 4 : (ch < 0 ? 2 : 1)));
      if (ia && ch >= 0 && cack)
      begin
        cnt[ch]--;
        lc = ch;
      end
      pa = pa && !ia;
      pd = pd && ia;
      arb_v <= pa;
      dreq <= pd;
    end
    @(posedge ref_clk);
  endtask : run

  // ==========================================================
  // main sequence
  initial
  begin
    {awv, wv, bq, arv, rq, arb_v, dreq, brk, den} = '0;
    {awa, ara, wd, il, gl, slow} = '0;
    rst = 1'b1;
    {stat, dl, lc, errors, compares} = '0;
    void'($urandom(32'hB9408CB1));
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    // reset values, then write-only, unmapped and read-only places
    for (int x = 0; x < 13; x++)
      if (x != 10) axr(8'(4 * x), 32'h0, `ECPM_RESP_OK);
    axr(`ECPM_OFF_CLR, 32'h0, `ECPM_RESP_ERR);
    axr(8'h40, 32'h0, `ECPM_RESP_ERR);
    axw(`ECPM_OFF_STAT, 32'hF, `ECPM_RESP_ERR);
    // one transfer left on each channel, random level selects
    for (int x = 0; x < 8; x++)
    begin
      ls[x] = 2'($urandom);
      lk[x] = 1'b0;
      cnt[x] = 1;
      wch(x);
    end
    axw(`ECPM_OFF_EN, 32'hF, `ECPM_RESP_OK);
    // each channel twice: the second hit finds its count spent if the first was acked
    for (int x = 0; x < 16; x++)
      run(1'b1, 1'b0, {1'b1, ~ls[x % 8], 1'((x % 8) / 4)},
          {1'b0, 2'(x)});
    repeat (12) run(1'b1, 1'b0, 4'($urandom), 3'($urandom));
    // linked pair: odd channel falls back to a plain interrupt
    lk[0] = 1'b1;
    cnt[0] = 5;
    cnt[1] = 5;
    wch(0);
    wch(1);
    run(1'b1, 1'b0, {1'b1, ~ls[1], 1'b0}, 3'h1);
    run(1'b1, 1'b0, {1'b1, ~ls[0], 1'b0}, 3'h0);
    // debug against winners at equal and higher debug level
    dl = 10;
    axw(`ECPM_OFF_DBGLVL, 32'hA, `ECPM_RESP_OK);
    run(1'b1, 1'b1, 4'hA, 3'h4);
    run(1'b1, 1'b1, 4'h9, 3'h4);
    run(1'b0, 1'b1, 4'h0, 3'h0);
    repeat (6)
    begin
      brk <= 1'($urandom);
      @(posedge ref_clk);
      chk(brk_o === brk, "break path");
    end
    // status, masking and clearing of the interrupt line
    axr(`ECPM_OFF_STAT, 32'(stat), `ECPM_RESP_OK);
    chk(irq === (stat != 0), "irq raised");
    // last acked transfer channel, no winner pending
    axr(`ECPM_OFF_SERVE, 32'(lc), `ECPM_RESP_OK);
    axw(`ECPM_OFF_EN, 32'h0, `ECPM_RESP_OK);
    chk(irq === 1'b0, "irq masked");
    axw(`ECPM_OFF_EN, 32'hF, `ECPM_RESP_OK);
    axw(`ECPM_OFF_CLR, 32'hF, `ECPM_RESP_OK);
    axr(`ECPM_OFF_STAT, 32'h0, `ECPM_RESP_OK);
    chk(irq === 1'b0, "irq cleared");
    summarize();
  end
endmodule : event_channel_priority_map_tb
